// [logic/e3r_alarm.sv]
// e3 receive alarm detection, status, interrupt enables and register port for one channel
// assumes frame_stb pulses once per received frame with the maintenance byte fields and zero count valid,
// and that framer event inputs are one-cycle pulses in this clock domain
`timescale 1ns/100ps
`include "e3r_regs.svh"
// How it works
// - two consecutive frames each holding under seven zeros declare the alarm indication
// - alarm indication status bit shows 1 while declared, 0 when absent
// - payload unstable bit is 1 if payload kind changed over last 5 frames
// - marker status shows the last value validated by consecutive consistent frames
// - marker validation needs 3 frames when select is 0, else 5
// - far failure declared after 3 or 5 consecutive frames with failure bit 1
// - far failure negated after the same count of frames with failure bit 0
// - far failure select 0 uses 3 frames, select 1 uses 5
// - far failure status bit reads 1 while declared, else 0
// - first enable register holds seven interrupt enables, 1 enables
// - in the 1995 framing revision both sync status message enables are ignored
// - second enable register holds trail trace, block error, failure, bip, framing, mismatch
// - bit 5 of second enable register is a writable message frame enable
module e3r_alarm #(
  parameter int ZERO_W = 13
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire e3r_pkg::e3r_byte_type wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output e3r_pkg::e3r_byte_type rd_data,
  input wire logic frame_stb,
  input wire logic [ZERO_W-1:0] frame_zeros,
  input wire e3r_pkg::e3r_pld_type maintenance_byte_pld,
  input wire logic maintenance_byte_marker,
  input wire logic maintenance_byte_far,
  input wire logic lof_state,
  input wire logic oof_state,
  input wire logic los_state,
  input wire logic sync_status_message_change,
  input wire logic sync_status_message_oos_change,
  input wire logic alignment_change,
  input wire logic oof_change,
  input wire logic lof_change,
  input wire logic los_change,
  input wire logic trail_trace_buffer_change,
  input wire logic lapd_message,
  input wire logic far_block_error,
  input wire logic bip8_error,
  input wire logic framing_byte_error,
  output logic alarm_indication_flag,
  output logic payload_kind_unstable_flag,
  output logic validated_marker_flag,
  output logic far_failure_flag,
  output logic irq
);
  import e3r_pkg::*;

  // frame-side state
  logic [1:0] ais_run_q, ais_run_d;
  logic ais_q, ais_d;
  e3r_pld_type pld_q, pld_d;
  e3r_pld_type hist_q [0:3];
  e3r_pld_type hist_d [0:3];
  logic [2:0] hist_cnt_q, hist_cnt_d;
  logic unstab_q, unstab_d;
  logic low_zero;
  logic pld_mis_evt;
  logic far_now, far_prev_q;
  logic marker_now;

  // register-side state
  e3r_byte_type cfg1_q, cfg1_d;
  logic lof_sel_q, lof_sel_d;
  e3r_byte_type en1_q, en1_d;
  e3r_byte_type en2_q, en2_d;
  e3r_byte_type ist1_q, ist1_d;
  e3r_byte_type ist2_q, ist2_d;
  logic rev1995_q, rev1995_d;
  e3r_byte_type rd_q, rd_d;
  logic irq_q, irq_d;
  e3r_byte_type evt1, evt2, clr1, clr2, en1_eff;

  // alarm indication and payload stability per frame
  always_comb
  begin
    low_zero = frame_zeros < ZERO_W'(`E3R_AIS_ZEROS);
    ais_run_d = ais_run_q;
    ais_d = ais_q;
    pld_d = pld_q;
    hist_cnt_d = hist_cnt_q;
    unstab_d = unstab_q;
    pld_mis_evt = 1'b0;
    for (int i = 0; i < 4; i++)
      hist_d[i] = hist_q[i];
    if (frame_stb)
    begin
      pld_d = maintenance_byte_pld;
      pld_mis_evt = maintenance_byte_pld != cfg1_q[2:0];
      if (low_zero)
      begin
        ais_run_d = (ais_run_q == 2'(`E3R_AIS_FRAMES)) ? ais_run_q : ais_run_q + 2'h1;
        if (ais_run_d == 2'(`E3R_AIS_FRAMES))
          ais_d = 1'b1;
      end
      else
      begin
        ais_run_d = 2'h0;
        ais_d = 1'b0;
      end
      // unstable unless the current and four prior payload kinds all agree
      unstab_d = hist_cnt_q < 3'(`E3R_PLD_FRAMES - 1);
      for (int i = 0; i < 4; i++)
        if (hist_q[i] != maintenance_byte_pld)
          unstab_d = 1'b1;
      hist_d[0] = maintenance_byte_pld;
      for (int i = 1; i < 4; i++)
        hist_d[i] = hist_q[i-1];
      if (hist_cnt_q < 3'(`E3R_PLD_FRAMES - 1))
        hist_cnt_d = hist_cnt_q + 3'h1;
    end
  end

  // frame-side registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ais_run_q <= 2'h0;
      ais_q <= `E3R_RST_FLAG;
      pld_q <= 3'h0;
      hist_cnt_q <= 3'h0;
      unstab_q <= `E3R_RST_FLAG;
      far_prev_q <= `E3R_RST_FLAG;
      for (int i = 0; i < 4; i++)
        hist_q[i] <= 3'h0;
    end
    else
    begin
      ais_run_q <= ais_run_d;
      ais_q <= ais_d;
      pld_q <= pld_d;
      hist_cnt_q <= hist_cnt_d;
      unstab_q <= unstab_d;
      far_prev_q <= far_now;
      for (int i = 0; i < 4; i++)
        hist_q[i] <= hist_d[i];
    end
  end

  // far failure declare and negate filter
  e3r_persist #(.RESET_VAL(`E3R_RST_FLAG)) u_far (
    .clk(clk),
    .rst(rst),
    .frame_stb(frame_stb),
    .sample(maintenance_byte_far),
    .long_sel(cfg1_q[`E3R_CFG1_FAR_SEL]),
    .flag(far_now)
  );

  // timing marker validation filter
  e3r_persist #(.RESET_VAL(`E3R_RST_FLAG)) u_mark (
    .clk(clk),
    .rst(rst),
    .frame_stb(frame_stb),
    .sample(maintenance_byte_marker),
    .long_sel(cfg1_q[`E3R_CFG1_MARK_SEL]),
    .flag(marker_now)
  );

  // register writes, sticky interrupt status and read data
  always_comb
  begin
    cfg1_d = cfg1_q;
    lof_sel_d = lof_sel_q;
    en1_d = en1_q;
    en2_d = en2_q;
    rev1995_d = rev1995_q;
    clr1 = 8'h00;
    clr2 = 8'h00;
    rd_d = 8'h00;
    if (wr_stb)
    begin
      case (addr)
        `E3R_OFF_CFG_ONE: cfg1_d = (cfg1_q & ~`E3R_CFG1_WMASK) | (wr_data & `E3R_CFG1_WMASK);
        `E3R_OFF_CFG_TWO: lof_sel_d = wr_data[`E3R_CFG2_LOF_SEL];
        `E3R_OFF_EN_ONE: en1_d = wr_data & `E3R_EN_WMASK;
        `E3R_OFF_EN_TWO: en2_d = wr_data & `E3R_EN_WMASK;
        `E3R_OFF_CLR_ONE: clr1 = wr_data;
        `E3R_OFF_CLR_TWO: clr2 = wr_data;
        `E3R_OFF_MODE: rev1995_d = wr_data[`E3R_MODE_REV1995];
        default: ;
      endcase
    end
    // received payload kind shows in the top bits of configuration one
    cfg1_d[7:5] = pld_d;
    evt1 = {1'b0, sync_status_message_change, sync_status_message_oos_change, alignment_change,
            oof_change, lof_change, los_change, ais_d != ais_q};
    evt2 = {1'b0, trail_trace_buffer_change, lapd_message, far_block_error,
            far_now != far_prev_q, bip8_error, framing_byte_error, pld_mis_evt};
    // a new event outweighs a clear in the same cycle
    ist1_d = (ist1_q & ~clr1) | evt1;
    ist2_d = (ist2_q & ~clr2) | evt2;
    en1_eff = rev1995_q ? (en1_q & ~`E3R_SSM_MASK) : en1_q;
    irq_d = |(ist1_d & en1_eff) | |(ist2_d & en2_q);
    if (rd_stb)
    begin
      case (addr)
        `E3R_OFF_CFG_ONE: rd_d = cfg1_q;
        `E3R_OFF_CFG_TWO: rd_d = {lof_sel_q, lof_state, oof_state, los_state,
                                  ais_q, unstab_q, marker_now, far_now};
        `E3R_OFF_EN_ONE: rd_d = en1_q;
        `E3R_OFF_EN_TWO: rd_d = en2_q;
        `E3R_OFF_IST_ONE: rd_d = ist1_q;
        `E3R_OFF_IST_TWO: rd_d = ist2_q;
        `E3R_OFF_MODE: rd_d = {7'h00, rev1995_q};
        default: rd_d = 8'h00;
      endcase
    end
  end

  // register-side flip-flops
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cfg1_q <= `E3R_RST_ZERO;
      lof_sel_q <= 1'b0;
      en1_q <= `E3R_RST_ZERO;
      en2_q <= `E3R_RST_ZERO;
      ist1_q <= `E3R_RST_ZERO;
      ist2_q <= `E3R_RST_ZERO;
      rev1995_q <= 1'b0;
      rd_q <= `E3R_RST_ZERO;
      irq_q <= 1'b0;
    end
    else
    begin
      cfg1_q <= cfg1_d;
      lof_sel_q <= lof_sel_d;
      en1_q <= en1_d;
      en2_q <= en2_d;
      ist1_q <= ist1_d;
      ist2_q <= ist2_d;
      rev1995_q <= rev1995_d;
      rd_q <= rd_d;
      irq_q <= irq_d;
    end
  end

  assign rd_data = rd_q;
  assign alarm_indication_flag = ais_q;
  assign payload_kind_unstable_flag = unstab_q;
  assign validated_marker_flag = marker_now;
  assign far_failure_flag = far_now;
  assign irq = irq_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence low_frame_s;
    frame_stb && frame_zeros < ZERO_W'(`E3R_AIS_ZEROS);
  endsequence

  // a low frame whose predecessor was low as well, since a normal frame empties the run
  ais_declare_a: assert property (low_frame_s ##0 (ais_run_q != 2'h0) |=> ais_q)
    else $error("alarm indication not declared after two low frames");
  ais_clear_a: assert property (frame_stb && !low_zero |=> !ais_q)
    else $error("alarm indication still set after a normal frame");
  ais_single_a: assert property (frame_stb && low_zero && ais_run_q == 2'h0 && !ais_q |=> !ais_q)
    else $error("alarm indication declared after one frame");
  unstab_change_a: assert property (frame_stb && maintenance_byte_pld != pld_q |=> unstab_q)
    else $error("payload change not flagged unstable");
  far_frame_only_a: assert property (!frame_stb |=> $stable(far_now) && $stable(marker_now))
    else $error("far failure or marker moved without a frame");
  set_wins_a: assert property (wr_stb && addr == `E3R_OFF_CLR_TWO && far_now != far_prev_q
                                 |=> ist2_q[`E3R_I2_FAR])
    else $error("event lost against a clear");
  set_wins_one_a: assert property (wr_stb && addr == `E3R_OFF_CLR_ONE && alignment_change
                                     |=> ist1_q[`E3R_I1_ALIGN])
    else $error("alignment event lost against a clear");
  irq_cause_a: assert property (irq_q |-> $past(ist1_d & en1_eff) != 8'h00 || $past(ist2_d & en2_q) != 8'h00)
    else $error("interrupt without enabled status");
  ssm_ignored_a: assert property (rev1995_q && (ist1_d & en1_q & ~`E3R_SSM_MASK) == 8'h00 &&
                                  (ist2_d & en2_q) == 8'h00 |=> !irq_q)
    else $error("sync status message enable honoured in 1995 revision");
  en2_lapd_a: assert property (wr_stb && addr == `E3R_OFF_EN_TWO |=> en2_q[`E3R_I2_LAPD] == $past(wr_data[5]))
    else $error("message frame enable not written");
  rd_idle_a: assert property (!rd_stb |=> rd_q == 8'h00)
    else $error("read data outside the read answer cycle");
endmodule

// [logic/e3r_persist.sv]
// consecutive-frame filter: output takes a bit value once it held for 3 or 5 frames
// assumes frame_stb is a one-cycle pulse per received frame, sample valid with it
`timescale 1ns/100ps
`include "e3r_regs.svh"
module e3r_persist #(
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic frame_stb,
  input wire logic sample,
  input wire logic long_sel,
  output logic flag
);
  import e3r_pkg::*;

  logic last_q, last_d;
  e3r_run_type run_q, run_d;
  logic flag_q, flag_d;
  logic [2:0] need;

  // run length of identical samples, output follows once the run is long enough
  always_comb
  begin
    need = long_sel ? 3'(`E3R_CNT_LONG) : 3'(`E3R_CNT_SHORT);
    last_d = last_q;
    run_d = run_q;
    flag_d = flag_q;
    if (frame_stb)
    begin
      last_d = sample;
      if (sample == last_q && run_q != E3R_RUN_NONE)
        run_d = (run_q == E3R_RUN_FIVE) ? E3R_RUN_FIVE : e3r_run_type'(run_q + 3'h1);
      else
        run_d = E3R_RUN_ONE;
      if (run_d >= need)
        flag_d = sample;
    end
  end

  // registers of the filter
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      last_q <= 1'b0;
      run_q <= E3R_RUN_NONE;
      flag_q <= RESET_VAL;
    end
    else
    begin
      last_q <= last_d;
      run_q <= run_d;
      flag_q <= flag_d;
    end
  end

  assign flag = flag_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  flag_moves_frame_a: assert property (!frame_stb |=> $stable(flag_q))
    else $error("filter output moved without a frame");
  short_run_a: assert property (!long_sel && frame_stb && run_d == E3R_RUN_THREE |=> flag_q == $past(sample))
    else $error("three-frame run did not update output");
endmodule

// [logic/e3r_pkg.sv]
// types shared by the e3 receive alarm block
// assumes e3r_regs.svh supplies the numeric constants
package e3r_pkg;
  typedef logic [7:0] e3r_byte_type;
  typedef logic [2:0] e3r_pld_type;
  typedef enum logic [2:0] {
    E3R_RUN_NONE = 3'h0,
    E3R_RUN_ONE = 3'h1,
    E3R_RUN_TWO = 3'h2,
    E3R_RUN_THREE = 3'h3,
    E3R_RUN_FOUR = 3'h4,
    E3R_RUN_FIVE = 3'h5
  } e3r_run_type;
endpackage

// [logic/e3r_regs.svh]
// register offsets, field positions, reset values and frame counts of the e3 receive alarm block
// assumes an 8-bit register port with printed byte offsets
`ifndef E3R_REGS_SVH
`define E3R_REGS_SVH

// register offsets
`define E3R_OFF_CFG_ONE 8'h10
`define E3R_OFF_CFG_TWO 8'h11
`define E3R_OFF_EN_ONE 8'h12
`define E3R_OFF_EN_TWO 8'h13
`define E3R_OFF_IST_ONE 8'h14
`define E3R_OFF_IST_TWO 8'h15
`define E3R_OFF_CLR_ONE 8'h16
`define E3R_OFF_CLR_TWO 8'h17
`define E3R_OFF_MODE 8'h18

// configuration one fields
`define E3R_CFG1_FAR_SEL 4
`define E3R_CFG1_MARK_SEL 3
`define E3R_CFG1_WMASK 8'h1F
// configuration two fields
`define E3R_CFG2_LOF_SEL 7
`define E3R_CFG2_AIS 3
`define E3R_CFG2_UNSTAB 2
`define E3R_CFG2_MARK 1
`define E3R_CFG2_FAR 0
// mode register fields
`define E3R_MODE_REV1995 0

// interrupt bit positions, first group
`define E3R_I1_SSM_MSG 6
`define E3R_I1_SSM_OOS 5
`define E3R_I1_ALIGN 4
`define E3R_I1_OOF 3
`define E3R_I1_LOF 2
`define E3R_I1_LOS 1
`define E3R_I1_AIS 0
// interrupt bit positions, second group
`define E3R_I2_TTB 6
`define E3R_I2_LAPD 5
`define E3R_I2_FAR_BLOCK_ERROR 4
`define E3R_I2_FAR 3
`define E3R_I2_BIP8 2
`define E3R_I2_FRAMING 1
`define E3R_I2_PLD_MIS 0
`define E3R_EN_WMASK 8'h7F
`define E3R_SSM_MASK 8'h60

// reset values
`define E3R_RST_ZERO 8'h00
`define E3R_RST_FLAG 1'b1

// frame counts
`define E3R_AIS_FRAMES 2
`define E3R_AIS_ZEROS 7
`define E3R_CNT_SHORT 3
`define E3R_CNT_LONG 5
`define E3R_PLD_FRAMES 5

`endif

// [verif/e3r_far_end.sv]
// far-end terminal model: sends one received frame with its maintenance byte fields on command
// assumes the bench calls send from its clocked sequence, one frame at a time
`timescale 1ns/100ps
module e3r_far_end #(
  parameter int ZERO_W = 13
) (
  input wire logic clk,
  output logic frame_stb,
  output logic [ZERO_W-1:0] frame_zeros,
  output e3r_pkg::e3r_pld_type pld,
  output logic marker,
  output logic far
);
  import e3r_pkg::*;
  // idle line: no frame
  initial
  begin
    frame_stb = 1'b0;
    frame_zeros = '0;
    pld = 3'h0;
    marker = 1'b0;
    far = 1'b0;
  end
  // fields are valid only beside the strobe, inverted afterwards so stale values never match
  task automatic send(input logic [ZERO_W-1:0] z, input e3r_pld_type p, input logic m, input logic f);
    @(posedge clk);
    frame_stb <= 1'b1;
    frame_zeros <= z;
    pld <= p;
    marker <= m;
    far <= f;
    @(posedge clk);
    frame_stb <= 1'b0;
    frame_zeros <= ~z;
    pld <= ~p;
    marker <= ~m;
    far <= ~f;
  endtask
endmodule

// [verif/tb_top.sv]
// self-checking bench for the e3 receive alarm block
// assumes the register port answers one cycle after the read strobe
`timescale 1ns/100ps
module tb_top;
  import e3r_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  e3r_byte_type wr_data = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  e3r_byte_type rd_data;
  logic [2:0] lvl = 3'h0;
  logic [6:0] ev1 = 7'h00;
  logic [6:0] ev2 = 7'h00;
  logic frame_stb, marker, far;
  logic [12:0] zeros;
  e3r_pld_type pld;
  logic ais_f, uns_f, mark_f, far_f, irq;
  int fail_count = 0;
  int num_checks = 0;

  // 250 MHz clock
  always #2 clk = ~clk;

  // far end and block under test
  e3r_far_end #(.ZERO_W(13)) u_e3r_far_end (.clk(clk), .frame_stb(frame_stb), .frame_zeros(zeros),
    .pld(pld), .marker(marker), .far(far));
  e3r_alarm #(.ZERO_W(13)) u_e3r_alarm (.clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .frame_stb(frame_stb), .frame_zeros(zeros),
    .maintenance_byte_pld(pld), .maintenance_byte_marker(marker), .maintenance_byte_far(far),
    .lof_state(lvl[2]), .oof_state(lvl[1]), .los_state(lvl[0]),
    .sync_status_message_change(ev1[6]), .sync_status_message_oos_change(ev1[5]),
    .alignment_change(ev1[4]), .oof_change(ev1[3]), .lof_change(ev1[2]), .los_change(ev1[1]),
    .trail_trace_buffer_change(ev2[6]), .lapd_message(ev2[5]), .far_block_error(ev2[4]),
    .bip8_error(ev2[2]), .framing_byte_error(ev2[1]), .alarm_indication_flag(ais_f),
    .payload_kind_unstable_flag(uns_f), .validated_marker_flag(mark_f), .far_failure_flag(far_f), .irq(irq));

  // compare helpers and bus cycles
  task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("mismatch %s expected %h seen %h", n, exp, got);
      fail_count++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    d = rd_data;
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic pulse(input bit g, input int i);
    @(posedge clk);
    if (g)
      ev2[i] <= 1'b1;
    else
      ev1[i] <= 1'b1;
    @(posedge clk);
    ev1 <= 7'h00;
    ev2 <= 7'h00;
  endtask
  task automatic fr(input logic [12:0] z, input logic [2:0] p, input logic v);
    u_e3r_far_end.send(z, p, v, v);
    settle();
  endtask

  // reset values and readback, unmapped read
  task automatic t_reset();
    logic [7:0] d;
    lvl <= 3'h5;
    rd(8'h11, d);
    chk("cfg_two", d, 8'h5F);
    chk("flags", {4'h0, ais_f, uns_f, mark_f, far_f}, 8'h0F);
    rd(8'h12, d);
    chk("en_one", d, 8'h00);
    rd(8'h13, d);
    chk("en_two", d, 8'h00);
    rd(8'h20, d);
    chk("unmapped", d, 8'h00);
    lvl <= 3'h0;
    $display("test reset done");
  endtask

  // enable registers hold writes, top bit reads zero
  task automatic t_enables();
    logic [7:0] d;
    wr(8'h12, 8'hFF);
    rd(8'h12, d);
    chk("en_one", d, 8'h7F);
    wr(8'h13, 8'hFF);
    rd(8'h13, d);
    chk("en_two", d, 8'h7F);
    wr(8'h13, 8'h20);
    rd(8'h13, d);
    chk("en_lapd", d, 8'h20);
    wr(8'h13, 8'h00);
    wr(8'h12, 8'h00);
    wr(8'h10, 8'hFF);
    rd(8'h10, d);
    chk("cfg_one", d, 8'h1F);
    wr(8'h10, 8'h00);
    wr(8'h11, 8'hFF);
    rd(8'h11, d);
    chk("cfg_two", d, 8'h8F);
    wr(8'h11, 8'h00);
    $display("test enables done");
  endtask

  // alarm indication needs two consecutive low-zero frames
  task automatic t_ais();
    logic [7:0] d;
    wr(8'h16, 8'hFF);
    wr(8'h12, 8'h01);
    fr(13'd7, 3'h0, 1'b0);
    chk("ais", {7'h00, ais_f}, 8'h00);
    chk("irq", {7'h00, irq}, 8'h01);
    wr(8'h16, 8'h01);
    fr(13'd6, 3'h0, 1'b0);
    chk("ais", {7'h00, ais_f}, 8'h00);
    chk("irq", {7'h00, irq}, 8'h00);
    fr(13'd6, 3'h0, 1'b0);
    chk("ais", {7'h00, ais_f}, 8'h01);
    rd(8'h11, d);
    chk("ais_reg", d & 8'h08, 8'h08);
    fr(13'd7, 3'h0, 1'b0);
    chk("ais", {7'h00, ais_f}, 8'h00);
    wr(8'h12, 8'h00);
    $display("test ais done");
  endtask

  // marker and far failure filters with both selects equal
  task automatic t_count(input logic sel);
    int n;
    logic [7:0] d;
    n = sel ? 5 : 3;
    wr(8'h10, {3'h0, sel, sel, 3'h0});
    repeat (n) fr(13'd20, 3'h0, 1'b0);
    chk("cnt_zero", {6'h00, mark_f, far_f}, 8'h00);
    repeat (n - 1) fr(13'd20, 3'h0, 1'b1);
    chk("cnt_early", {6'h00, mark_f, far_f}, 8'h00);
    fr(13'd20, 3'h0, 1'b1);
    chk("cnt_one", {6'h00, mark_f, far_f}, 8'h03);
    rd(8'h11, d);
    chk("cnt_reg", d & 8'h03, 8'h03);
    repeat (n - 1) fr(13'd20, 3'h0, 1'b0);
    fr(13'd20, 3'h0, 1'b1);
    repeat (n - 1) fr(13'd20, 3'h0, 1'b0);
    chk("cnt_hold", {6'h00, mark_f, far_f}, 8'h03);
    fr(13'd20, 3'h0, 1'b0);
    chk("cnt_neg", {6'h00, mark_f, far_f}, 8'h00);
    $display("test counts select %0d done", sel);
  endtask

  // far long, marker short: selects act separately
  task automatic t_mixed();
    wr(8'h10, 8'h10);
    repeat (5) fr(13'd20, 3'h0, 1'b0);
    repeat (3) fr(13'd20, 3'h0, 1'b1);
    chk("mixed", {6'h00, mark_f, far_f}, 8'h02);
    $display("test mixed done");
  endtask

  // payload kind stability over the last five frames
  task automatic t_uns();
    logic [7:0] d;
    repeat (5) fr(13'd20, 3'h3, 1'b0);
    chk("unstable", {7'h00, uns_f}, 8'h00);
    fr(13'd20, 3'h4, 1'b0);
    chk("unstable", {7'h00, uns_f}, 8'h01);
    repeat (3) fr(13'd20, 3'h4, 1'b0);
    chk("unstable", {7'h00, uns_f}, 8'h01);
    fr(13'd20, 3'h4, 1'b0);
    chk("unstable", {7'h00, uns_f}, 8'h00);
    rd(8'h10, d);
    chk("pld_kind", d & 8'hE0, 8'h80);
    rd(8'h15, d);
    chk("status_two", d & 8'h09, 8'h09);
    $display("test unstable done");
  endtask

  // each pulsed event: status set, irq only once enabled, cleared by write
  task automatic t_group(input bit g);
    logic [7:0] d;
    wr(8'h16 + g, 8'hFF);
    for (int i = 1; i < 7; i++)
    begin
      if (g && i == 3)
        continue;
      pulse(g, i);
      rd(8'h14 + g, d);
      chk("status", d, 8'h01 << i);
      chk("irq", {7'h00, irq}, 8'h00);
      wr(8'h12 + g, 8'h01 << i);
      settle();
      chk("irq", {7'h00, irq}, 8'h01);
      wr(8'h16 + g, 8'h01 << i);
      settle();
      chk("irq", {7'h00, irq}, 8'h00);
      wr(8'h12 + g, 8'h00);
    end
    $display("test group %0d done", g);
  endtask

  // the 1995 revision masks the message enables
  task automatic t_mode();
    logic [7:0] d;
    wr(8'h16, 8'hFF);
    wr(8'h12, 8'h60);
    pulse(1'b0, 6);
    settle();
    chk("irq", {7'h00, irq}, 8'h01);
    wr(8'h18, 8'h01);
    settle();
    chk("irq", {7'h00, irq}, 8'h00);
    rd(8'h18, d);
    chk("mode", d, 8'h01);
    wr(8'h18, 8'h00);
    settle();
    chk("irq", {7'h00, irq}, 8'h01);
    // alignment event and its clear in one cycle: the event must stay
    @(posedge clk);
    ev1[4] <= 1'b1;
    addr <= 8'h16;
    wr_data <= 8'h10;
    wr_stb <= 1'b1;
    @(posedge clk);
    ev1 <= 7'h00;
    wr_stb <= 1'b0;
    rd(8'h14, d);
    chk("set_wins", d & 8'h10, 8'h10);
    $display("test mode done");
  endtask

  // verdict
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_enables();
    t_ais();
    t_count(1'b0);
    t_count(1'b1);
    t_mixed();
    t_uns();
    t_group(1'b0);
    t_group(1'b1);
    t_mode();
    end_of_test();
  end

  // hang guard
  initial
  begin
    #100000;
    fail_count++;
    $display("mismatch watchdog expected finish seen timeout");
    end_of_test();
  end
endmodule
